// File: tmwc_defs.vh
/*
 * Constants of the 16-bit timer waveform mode control block: register
 * offsets, field positions, mode codes and fixed TOP values.
 * Assumes inclusion by the design file, the checker and the bench of the block.
 */
// What this block does
// - Timer tick is a clock enable; all activity on sys_clk edges.
// - Nonzero output mode connects channel compare output to its pin; toggle in PWM modes connects only A in modes 9 and 15.
// - Non-PWM: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM: mode 2 clear on match/set at BOTTOM; 3 opposite.
// - Fast PWM mode 1 toggles A only in wave mode 15, B off.
// - Fast PWM: compare equal TOP ignored, BOTTOM action still done.
// - Dual-slope: mode 2 clear up-match, set down-match; 3 opposite.
// - Dual-slope mode 1 toggles A only in wave mode 9.
// - Force strobe in non-PWM forces a match per output mode.
// - Forced match sets no flag and never clears counter.
// - Force strobe bits always read as zero.
// - Wave mode is four bits, two from each control register.
// - Modes 0,4,12: TOP FFFF/A/capture, immediate update, overflow at MAX.
// - Modes 1-3,10,11 phase correct: update at TOP, overflow at BOTTOM.
// - Modes 5-7,14,15 fast PWM: update BOTTOM, overflow TOP; 13 reserved.
// - Modes 8,9: TOP capture or A, update and overflow at BOTTOM.
// - Filter changes capture input after four equal samples.
// - Edge select 0 falling, 1 rising; capture copies count, sets flag.
// - Capture input disabled while capture register is TOP.
// - Clock select: stop, /1,/8,/64,/256,/1024, external fall/rise.
`ifndef TMWC_DEFS_VH
`define TMWC_DEFS_VH

`define TMWC_OFF_CTRL_A   4'h0
`define TMWC_OFF_CTRL_B   4'h4
`define TMWC_OFF_COUNT    4'h8
`define TMWC_OFF_CMP_A    4'hC
`define TMWC_OFF_CMP_B    5'h10
`define TMWC_OFF_CAPT     5'h14
`define TMWC_OFF_FLAGS    5'h18
`define TMWC_ADDR_W       5

`define TMWC_RESP_OKAY    2'h0
`define TMWC_RESP_SLVERR  2'h2

// Control A fields
`define TMWC_A_OMA_HI     7
`define TMWC_A_OMA_LO     6
`define TMWC_A_OMB_HI     5
`define TMWC_A_OMB_LO     4
`define TMWC_A_FRC_A      3
`define TMWC_A_FRC_B      2
// Control B fields
`define TMWC_B_FILT       7
`define TMWC_B_EDGE       6
`define TMWC_B_CSEL_HI    2
// Flag register bits (write one clears)
`define TMWC_F_CAPT       2
`define TMWC_F_CMPA       1
`define TMWC_F_CMPB       0
`define TMWC_F_OVF        3

`define TMWC_RST_CTRL     8'h00
`define TMWC_MAX          16'hFFFF
`define TMWC_BOTTOM       16'h0000
`define TMWC_TOP8         16'h00FF
`define TMWC_TOP9         16'h01FF
`define TMWC_TOP10        16'h03FF

`define TMWC_OM_OFF       2'h0
`define TMWC_OM_TOG       2'h1
`define TMWC_OM_CLR       2'h2
`define TMWC_OM_SET       2'h3

`define TMWC_WM_PFC_CAPT  4'h8
`define TMWC_WM_PFC_A     4'h9
`define TMWC_WM_PC_CAPT   4'hA
`define TMWC_WM_CTC_CAPT  4'hC
`define TMWC_WM_RSVD      4'hD
`define TMWC_WM_FAST_CAPT 4'hE
`define TMWC_WM_FAST_A    4'hF
`define TMWC_WM_CTC_A     4'h4

`define TMWC_CS_STOP      3'h0
`define TMWC_CS_D1        3'h1
`define TMWC_CS_D8        3'h2
`define TMWC_CS_D64       3'h3
`define TMWC_CS_D256      3'h4
`define TMWC_CS_D1024     3'h5
`define TMWC_CS_EXTF      3'h6
`define TMWC_CS_EXTR      3'h7

`define TMWC_PRE_W        10
`define TMWC_FILT_N       4

// Update point / overflow point codes
`define TMWC_PT_IMM       2'h0
`define TMWC_PT_TOP       2'h1
`define TMWC_PT_BOT       2'h2
`define TMWC_PT_MAX       2'h3

`endif

// File: tmwc_timer16.v
/*
 * 16-bit timer with waveform mode decode, two compare outputs, force
 * strobes, prescaler and input capture with noise filter, on AXI4-Lite.
 * Assumes one 100 MHz clock; pin inputs are asynchronous and are
 * synchronised here; pin direction is kept outside this block.
 */
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "tmwc_defs.vh"

module tmwc_timer16 (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_b,
	// AXI4-Lite write address
	input  wire [`TMWC_ADDR_W-1:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read
	input  wire [`TMWC_ADDR_W-1:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Pins
	input  wire        captureIn,
	input  wire        extCountIn,
	output reg         waveOutA,
	output reg         waveOutB,
	output wire        waveConnA,
	output wire        waveConnB
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function [1:0] applyMode;
		input [1:0] om;
		input       cur;
		begin
			case (om)
				`TMWC_OM_TOG: applyMode = {1'b1, ~cur};
				`TMWC_OM_CLR: applyMode = 2'h2;
				`TMWC_OM_SET: applyMode = 2'h3;
				default:      applyMode = {1'b0, cur};
			endcase
		end
	endfunction

	function byteWr;
		input [3:0] strb;
		begin
			byteWr = strb[0];
		end
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [7:0]  ctrlA_q;
	reg  [7:0]  ctrlB_q;
	reg  [15:0] count_q;
	reg  [15:0] cmpA_q, cmpB_q, bufA_q, bufB_q;
	reg  [15:0] capt_q;
	reg  [3:0]  flags_q;
	reg         down_q;
	reg  [`TMWC_PRE_W-1:0] pre_q;
	reg  [2:0]  capSync_q, extSync_q;
	reg         capStable_q, extStable_q;
	reg  [`TMWC_FILT_N-1:0] filtHist_q;
	reg         capFilt_q;
	reg         aw_q, w_q;
	reg         forcePendA_q, forcePendB_q;
	reg  [`TMWC_ADDR_W-1:0] awAddr_q;
	reg  [31:0] wData_q;
	reg  [3:0]  wStrb_q;

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	wire [3:0] waveMode = {ctrlB_q[4:3], ctrlA_q[1:0]};
	wire [1:0] outModeA = ctrlA_q[`TMWC_A_OMA_HI:`TMWC_A_OMA_LO];
	wire [1:0] outModeB = ctrlA_q[`TMWC_A_OMB_HI:`TMWC_A_OMB_LO];
	wire [2:0] clockSel = ctrlB_q[`TMWC_B_CSEL_HI:0];

	wire isNonPwm = (waveMode == 4'h0) || (waveMode == `TMWC_WM_CTC_A) || (waveMode == `TMWC_WM_CTC_CAPT);
	wire isFast   = (waveMode[2:0] >= 3'h5 && !waveMode[3]) ||
	                (waveMode == `TMWC_WM_FAST_CAPT) || (waveMode == `TMWC_WM_FAST_A);
	wire isDual   = !isNonPwm && !isFast && (waveMode != `TMWC_WM_RSVD);
	wire captIsTop = (waveMode == `TMWC_WM_PFC_CAPT) || (waveMode == `TMWC_WM_PC_CAPT) ||
	                 (waveMode == `TMWC_WM_CTC_CAPT) || (waveMode == `TMWC_WM_FAST_CAPT);

	reg [15:0] topVal;
	reg [1:0]  updPt, ovfPt;
	always @* begin
		case (waveMode)
			4'h0: begin topVal = `TMWC_MAX; updPt = `TMWC_PT_IMM; ovfPt = `TMWC_PT_MAX; end
			4'h1: begin topVal = `TMWC_TOP8; updPt = `TMWC_PT_TOP; ovfPt = `TMWC_PT_BOT; end
			4'h2: begin topVal = `TMWC_TOP9; updPt = `TMWC_PT_TOP; ovfPt = `TMWC_PT_BOT; end
			4'h3: begin topVal = `TMWC_TOP10; updPt = `TMWC_PT_TOP; ovfPt = `TMWC_PT_BOT; end
			4'h4: begin topVal = cmpA_q; updPt = `TMWC_PT_IMM; ovfPt = `TMWC_PT_MAX; end
			4'h5: begin topVal = `TMWC_TOP8; updPt = `TMWC_PT_BOT; ovfPt = `TMWC_PT_TOP; end
			4'h6: begin topVal = `TMWC_TOP9; updPt = `TMWC_PT_BOT; ovfPt = `TMWC_PT_TOP; end
			4'h7: begin topVal = `TMWC_TOP10; updPt = `TMWC_PT_BOT; ovfPt = `TMWC_PT_TOP; end
			4'h8: begin topVal = capt_q; updPt = `TMWC_PT_BOT; ovfPt = `TMWC_PT_BOT; end
			4'h9: begin topVal = cmpA_q; updPt = `TMWC_PT_BOT; ovfPt = `TMWC_PT_BOT; end
			4'hA: begin topVal = capt_q; updPt = `TMWC_PT_TOP; ovfPt = `TMWC_PT_BOT; end
			4'hB: begin topVal = cmpA_q; updPt = `TMWC_PT_TOP; ovfPt = `TMWC_PT_BOT; end
			4'hC: begin topVal = capt_q; updPt = `TMWC_PT_IMM; ovfPt = `TMWC_PT_MAX; end
			4'hE: begin topVal = capt_q; updPt = `TMWC_PT_BOT; ovfPt = `TMWC_PT_TOP; end
			4'hF: begin topVal = cmpA_q; updPt = `TMWC_PT_BOT; ovfPt = `TMWC_PT_TOP; end
			// Reserved mode 13 behaves as a free counter with no waveform
			default: begin topVal = `TMWC_MAX; updPt = `TMWC_PT_IMM; ovfPt = `TMWC_PT_MAX; end
		endcase
	end

	// ----------------------------------------
	// Pin synchronisers and capture filter
	// ----------------------------------------
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			capSync_q   <= 3'h0;
			extSync_q   <= 3'h0;
			capStable_q <= 1'b0;
			extStable_q <= 1'b0;
			filtHist_q  <= {`TMWC_FILT_N{1'b0}};
			capFilt_q   <= 1'b0;
		end else begin
			capSync_q <= {capSync_q[1:0], captureIn};
			extSync_q <= {extSync_q[1:0], extCountIn};
			if (capSync_q[2] == capSync_q[1])
				capStable_q <= capSync_q[2];
			if (extSync_q[2] == extSync_q[1])
				extStable_q <= extSync_q[2];
			filtHist_q <= {filtHist_q[`TMWC_FILT_N-2:0], capStable_q};
			if (!ctrlB_q[`TMWC_B_FILT])
				capFilt_q <= capStable_q;
			else if (&filtHist_q || ~|filtHist_q)
				capFilt_q <= filtHist_q[`TMWC_FILT_N-1];
		end
	end

	wire capPrev;
	reg  capPrev_q;
	assign capPrev = capPrev_q;
	wire capEdge = ctrlB_q[`TMWC_B_EDGE] ? (capFilt_q & ~capPrev) : (~capFilt_q & capPrev);
	wire capEvent = capEdge && !captIsTop;
	reg  extPrev_q;
	wire extFall = extPrev_q & ~extStable_q;
	wire extRise = ~extPrev_q & extStable_q;

	// ----------------------------------------
	// Prescaler and tick enable
	// ----------------------------------------
	reg tickEnable;
	always @* begin
		case (clockSel)
			`TMWC_CS_D1:    tickEnable = 1'b1;
			`TMWC_CS_D8:    tickEnable = &pre_q[2:0];
			`TMWC_CS_D64:   tickEnable = &pre_q[5:0];
			`TMWC_CS_D256:  tickEnable = &pre_q[7:0];
			`TMWC_CS_D1024: tickEnable = &pre_q[9:0];
			`TMWC_CS_EXTF:  tickEnable = extFall;
			`TMWC_CS_EXTR:  tickEnable = extRise;
			default:        tickEnable = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire   wrDo = aw_q && w_q && !s_axi_bvalid;
	wire   wrHit = wrDo && byteWr(wStrb_q);
	wire   wrCtrlA = wrHit && (awAddr_q == {1'b0, `TMWC_OFF_CTRL_A});
	wire   wrCtrlB = wrHit && (awAddr_q == {1'b0, `TMWC_OFF_CTRL_B});
	wire   wrCount = wrDo && (awAddr_q == {1'b0, `TMWC_OFF_COUNT});
	wire   wrCmpA  = wrDo && (awAddr_q == {1'b0, `TMWC_OFF_CMP_A});
	wire   wrCmpB  = wrDo && (awAddr_q == `TMWC_OFF_CMP_B);
	wire   wrCapt  = wrDo && (awAddr_q == `TMWC_OFF_CAPT);
	wire   wrFlags = wrHit && (awAddr_q == `TMWC_OFF_FLAGS);
	wire   wrMapped = wrCtrlA || wrCtrlB || wrCount || wrCmpA || wrCmpB || wrCapt || wrFlags ||
	                  (awAddr_q[1:0] == 2'h0 && awAddr_q <= `TMWC_OFF_FLAGS);

	// Strobes act one cycle after the write, so the modes written with them decide
	wire forceA = forcePendA_q && isNonPwm;
	wire forceB = forcePendB_q && isNonPwm;

	// ----------------------------------------
	// Counter sequencing
	// ----------------------------------------
	wire atTop    = (count_q == topVal);
	wire atBottom = (count_q == `TMWC_BOTTOM);
	wire matchA   = tickEnable && (count_q == cmpA_q);
	wire matchB   = tickEnable && (count_q == cmpB_q);
	wire atMax    = (count_q == `TMWC_MAX);
	wire ovfHit   = tickEnable && ((ovfPt == `TMWC_PT_MAX && atMax) ||
	                (ovfPt == `TMWC_PT_TOP && atTop) || (ovfPt == `TMWC_PT_BOT && atBottom && down_q));
	wire updHit   = tickEnable && ((updPt == `TMWC_PT_TOP && atTop) || (updPt == `TMWC_PT_BOT && atBottom));

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q   <= 16'h0000;
			down_q    <= 1'b0;
			pre_q     <= {`TMWC_PRE_W{1'b0}};
			capPrev_q <= 1'b0;
			extPrev_q <= 1'b0;
		end else begin
			capPrev_q <= capFilt_q;
			extPrev_q <= extStable_q;
			pre_q     <= (clockSel == `TMWC_CS_STOP) ? pre_q : pre_q + 1'b1;
			if (wrCount)
				count_q <= wData_q[15:0];
			else if (tickEnable) begin
				if (isDual) begin
					if (atTop) begin
						down_q  <= 1'b1;
						count_q <= count_q - 1'b1;
					end else if (atBottom && down_q) begin
						down_q  <= 1'b0;
						count_q <= count_q + 1'b1;
					end else
						count_q <= down_q ? count_q - 1'b1 : count_q + 1'b1;
				end else if (waveMode != 4'h0 && atTop)
					count_q <= `TMWC_BOTTOM;
				else
					count_q <= count_q + 1'b1;
				if (!isDual)
					down_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Waveform outputs
	// ----------------------------------------
	// In PWM modes, toggle mode is kept only by channel A in modes 15 and 9
	wire togOkA = isNonPwm || (isFast && waveMode == `TMWC_WM_FAST_A) ||
	              (isDual && (waveMode == `TMWC_WM_PFC_A || waveMode == `TMWC_WM_FAST_CAPT));
	assign waveConnA = (outModeA != `TMWC_OM_OFF) && (outModeA != `TMWC_OM_TOG || togOkA);
	assign waveConnB = (outModeB != `TMWC_OM_OFF) && (outModeB != `TMWC_OM_TOG || isNonPwm);

	function nextWave;
		input [1:0]  om;
		input        cur;
		input        hit;
		input        frc;
		input [15:0] cmp;
		reg   [1:0]  r;
		begin
			r = {1'b0, cur};
			if (isNonPwm && (hit || frc))
				r = applyMode(om, cur);
			else if (isFast && om[1]) begin
				if (hit && cmp != topVal)
					r = {1'b1, om[0]};
				else if (tickEnable && atTop)
					r = {1'b1, ~om[0]};
			end else if (isFast && om == `TMWC_OM_TOG && hit)
				r = {1'b1, ~cur};
			else if (isDual && om[1] && hit)
				r = {1'b1, om[0] ^ down_q};
			else if (isDual && om == `TMWC_OM_TOG && hit)
				r = {1'b1, ~cur};
			nextWave = r[0];
		end
	endfunction

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			waveOutA <= 1'b0;
			waveOutB <= 1'b0;
		end else begin
			if (waveConnA)
				waveOutA <= nextWave(outModeA, waveOutA, matchA, forceA, cmpA_q);
			if (waveConnB)
				waveOutB <= nextWave(outModeB, waveOutB, matchB, forceB, cmpB_q);
		end
	end

	// ----------------------------------------
	// Registers, flags and bus slave
	// ----------------------------------------
	wire [15:0] wr16 = wData_q[15:0];
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrlA_q <= `TMWC_RST_CTRL;
			ctrlB_q <= `TMWC_RST_CTRL;
			cmpA_q <= 16'h0000;
			cmpB_q <= 16'h0000;
			bufA_q <= 16'h0000;
			bufB_q <= 16'h0000;
			capt_q <= 16'h0000;
			flags_q <= 4'h0;
			aw_q <= 1'b0;
			w_q <= 1'b0;
			forcePendA_q <= 1'b0;
			forcePendB_q <= 1'b0;
			awAddr_q <= {`TMWC_ADDR_W{1'b0}};
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TMWC_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `TMWC_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (wrDo) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrMapped ? `TMWC_RESP_OKAY : `TMWC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wrCtrlA)
				ctrlA_q <= {wData_q[7:4], 2'b00, wData_q[1:0]};
			forcePendA_q <= wrCtrlA && wData_q[`TMWC_A_FRC_A];
			forcePendB_q <= wrCtrlA && wData_q[`TMWC_A_FRC_B];
			if (wrCtrlB)
				ctrlB_q <= {wData_q[7:6], 1'b0, wData_q[4:0]};
			// Compare writes go to the buffer; immediate modes copy at once
			if (wrCmpA)
				bufA_q <= wr16;
			if (wrCmpB)
				bufB_q <= wr16;
			if (updPt == `TMWC_PT_IMM) begin
				cmpA_q <= wrCmpA ? wr16 : bufA_q;
				cmpB_q <= wrCmpB ? wr16 : bufB_q;
			end else if (updHit) begin
				cmpA_q <= bufA_q;
				cmpB_q <= bufB_q;
			end
			if (capEvent)
				capt_q <= count_q;
			else if (wrCapt && captIsTop)
				capt_q <= wr16;
			// Set beats clear; forced matches never reach the flags
			flags_q[`TMWC_F_CAPT] <= (capEvent || (captIsTop && tickEnable && atTop)) ||
				(flags_q[`TMWC_F_CAPT] && !(wrFlags && wData_q[`TMWC_F_CAPT]));
			flags_q[`TMWC_F_CMPA] <= matchA || (flags_q[`TMWC_F_CMPA] && !(wrFlags && wData_q[`TMWC_F_CMPA]));
			flags_q[`TMWC_F_CMPB] <= matchB || (flags_q[`TMWC_F_CMPB] && !(wrFlags && wData_q[`TMWC_F_CMPB]));
			flags_q[`TMWC_F_OVF] <= ovfHit || (flags_q[`TMWC_F_OVF] && !(wrFlags && wData_q[`TMWC_F_OVF]));
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `TMWC_RESP_OKAY;
				case (s_axi_araddr)
					{1'b0, `TMWC_OFF_CTRL_A}: s_axi_rdata <= {24'h000000, ctrlA_q};
					{1'b0, `TMWC_OFF_CTRL_B}: s_axi_rdata <= {24'h000000, ctrlB_q};
					{1'b0, `TMWC_OFF_COUNT}:  s_axi_rdata <= {16'h0000, count_q};
					{1'b0, `TMWC_OFF_CMP_A}:  s_axi_rdata <= {16'h0000, bufA_q};
					`TMWC_OFF_CMP_B:          s_axi_rdata <= {16'h0000, bufB_q};
					`TMWC_OFF_CAPT:           s_axi_rdata <= {16'h0000, capt_q};
					`TMWC_OFF_FLAGS:          s_axi_rdata <= {28'h0000000, flags_q};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `TMWC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule // tmwc_timer16

// File: tmwc_pin_model.sv
/* Far-side model of tmwc_timer16: capture and count pins follow bench levels,
   compare pins are resolved with the port direction and a pull-up.
   Assumes the bench changes its levels just after a rising clock edge. */
`timescale 1ns/1ps

module tmwc_pin_model (
	// Bench levels
	input logic	capLvl,
	input logic	extLvl,
	input logic	dirA,
	input logic	dirB,
	// Design side
	input logic	waveOutA,
	input logic	waveOutB,
	input logic	waveConnA,
	input logic	waveConnB,
	// Pins
	output logic	captureIn,
	output logic	extCountIn,
	output logic	pinA,
	output logic	pinB
);
	assign captureIn = capLvl;
	assign extCountIn = extLvl;
	// Pull-up shows while the direction bit keeps the driver off
	assign pinA = (waveConnA && dirA) ? waveOutA : 1'h1;
	assign pinB = (waveConnB && dirB) ? waveOutB : 1'h1;
endmodule // tmwc_pin_model

// File: tmwc_timer16_assertions.sv
/* Assertions for tmwc_timer16 seen from its ports: bus answers, pin
   connection map and force strobes; bound at the foot of this file.
   Assumes full-word register writes from the master. */
`timescale 1ns/1ps
`include "tmwc_defs.vh"

module tmwc_checker (
	// Clock and reset
	input logic				sys_clk,
	input logic				rst_b,
	// Register bus
	input logic [`TMWC_ADDR_W-1:0]	s_axi_awaddr,
	input logic				s_axi_awvalid,
	input logic				s_axi_awready,
	input logic [31:0]		s_axi_wdata,
	input logic				s_axi_wvalid,
	input logic				s_axi_wready,
	input logic				s_axi_bvalid,
	input logic [`TMWC_ADDR_W-1:0]	s_axi_araddr,
	input logic				s_axi_arvalid,
	input logic				s_axi_arready,
	input logic [31:0]		s_axi_rdata,
	input logic [1:0]		s_axi_rresp,
	input logic				s_axi_rvalid,
	// Pins
	input logic				waveOutA,
	input logic				waveConnA,
	input logic				waveConnB
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	logic [4:0]	awA;
	logic [4:0]	arA;
	logic [7:0]	wD;
	logic [7:0]	ctlA;
	logic [7:0]	ctlB;
	logic		awH;
	logic		wH;
	// Shadow commits on the same edge the slave commits
	wire		commit = awH && wH && !s_axi_bvalid;
	wire [3:0]	wm = {ctlB[4:3], ctlA[1:0]};
	wire [3:0]	wmNew = {ctlB[4:3], wD[1:0]};

	function automatic logic nonPwm(input logic [3:0] m);
		return m == 4'h0 || m == `TMWC_WM_CTC_A || m == `TMWC_WM_CTC_CAPT;
	endfunction

	function automatic logic conn(input logic [1:0] om, input logic [3:0] m, input logic isA);
		if (om != `TMWC_OM_TOG)
			return om != `TMWC_OM_OFF;
		return nonPwm(m) || (isA && (m == `TMWC_WM_FAST_A || m == `TMWC_WM_PFC_A));
	endfunction

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			{awH, wH, ctlA, ctlB} <= 18'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awH <= 1'h1;
				awA <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wH <= 1'h1;
				wD <= s_axi_wdata[7:0];
			end
			if (s_axi_arvalid && s_axi_arready)
				arA <= s_axi_araddr;
			if (commit) begin
				awH <= 1'h0;
				wH <= 1'h0;
				if (awA == 5'h00)
					ctlA <= wD;
				if (awA == 5'h04)
					ctlB <= wD;
			end
		end
	end

	sequence bothTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	// Force write landing while the timer is stopped
	sequence frcWr;
		commit && awA == 5'h00 && wD[3] && ctlB[2:0] == `TMWC_CS_STOP;
	endsequence

	a_write_answer: assert property (bothTaken |-> ##2 s_axi_bvalid)
		else $error("write not answered in two cycles");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_unmapped_read: assert property (s_axi_rvalid && arA > 5'h18 |->
		s_axi_rresp == `TMWC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	a_force_reads_zero: assert property (s_axi_rvalid && arA == 5'h00 |-> s_axi_rdata[3:2] == 2'h0)
		else $error("force bits read back");
	a_conn_a_map: assert property ((wm < 4'hD || wm == 4'hF) |-> waveConnA == conn(ctlA[7:6], wm, 1'h1))
		else $error("channel A connection wrong");
	a_conn_b_map: assert property ((wm < 4'hD || wm == 4'hF) |-> waveConnB == conn(ctlA[5:4], wm, 1'h0))
		else $error("channel B connection wrong");
	a_force_clear: assert property (frcWr ##0 nonPwm(wmNew) && wD[7:6] == `TMWC_OM_CLR |-> ##[1:2] !waveOutA)
		else $error("forced clear missing");
	a_force_set: assert property (frcWr ##0 nonPwm(wmNew) && wD[7:6] == `TMWC_OM_SET |-> ##[1:2] waveOutA)
		else $error("forced set missing");
	a_force_pwm_off: assert property (frcWr ##0 !nonPwm(wmNew) && wmNew != 4'hD |=> $stable(waveOutA) [*2])
		else $error("force acted in a PWM mode");
endmodule // tmwc_checker

bind tmwc_timer16 tmwc_checker u_chk (.*);

// File: tmwc_timer16_tb.sv
/* Self-checking bench for tmwc_timer16: AXI4-Lite master tasks, mode sweep,
   force strobes, TOP limits, clock sources and capture edges.
   Assumes the pin model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`include "tmwc_defs.vh"

module tmwc_timer16_tb;
	logic			sys_clk = 1'h0;
	logic			rst_b = 1'h0;
	logic [4:0]		s_axi_awaddr = 5'h00;
	logic [31:0]	s_axi_wdata = 32'h0;
	logic [3:0]		s_axi_wstrb = 4'hF;
	logic [4:0]		s_axi_araddr = 5'h00;
	logic			s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic			s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic			s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]		s_axi_bresp, s_axi_rresp;
	logic [31:0]	s_axi_rdata;
	logic			captureIn, extCountIn, waveOutA, waveOutB, waveConnA, waveConnB;
	logic			capLvl = 1'h0, extLvl = 1'h0, dirA = 1'h0, dirB = 1'h0, pinA, pinB;
	int				n_errors = 0, checks = 0, cyc = 0;
	logic [1:0]		wResp;

	tmwc_timer16 dut (.*);
	tmwc_pin_model model (.*);

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Whole test needs about 10000 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			$display("BAD %0t timeout", $time);
			end_sim;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		fork
			begin
				do @(posedge sys_clk); while (!s_axi_awready);
				s_axi_awvalid <= 1'h0;
			end
			begin
				do @(posedge sys_clk); while (!s_axi_wready);
				s_axi_wvalid <= 1'h0;
			end
		join
		do @(posedge sys_clk); while (!s_axi_bvalid);
		wResp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic rc(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, exp);
	endtask

	function automatic logic nonPwm(input logic [3:0] m);
		return m == 4'h0 || m == 4'h4 || m == 4'hC;
	endfunction

	function automatic logic expConn(input logic [1:0] om, input logic [3:0] m, input logic isA);
		if (om != 2'h1)
			return om != 2'h0;
		return nonPwm(m) || (isA && (m == 4'hF || m == 4'h9));
	endfunction

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [3:0] m;
		logic [1:0] oa;
		logic [1:0] ob;
		logic [7:0] a8;
		logic [15:0] top;
		void'($urandom(7));
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'h1;
		rc(`TMWC_OFF_CTRL_A, 32'h0);
		rc(`TMWC_OFF_CTRL_B, 32'h0);
		rd(5'h1C, d, r);
		chk({30'h0, r}, {30'h0, `TMWC_RESP_SLVERR});
		wr(5'h1C, 32'h0);
		chk(wResp, `TMWC_RESP_SLVERR);
		// ---------------------------------------
		// Every wave mode with random output modes
		// ---------------------------------------
		for (int i = 0; i < 48; i++) begin
			m = i[3:0];
			{oa, ob} = 4'($urandom);
			dirA <= 1'($urandom);
			dirB <= 1'($urandom);
			wr(`TMWC_OFF_CTRL_B, {24'h0, 3'h1, m[3:2], `TMWC_CS_STOP});
			a8 = {oa, ob, nonPwm(m) ? 2'h3 : 2'h0, m[1:0]};
			wr(`TMWC_OFF_CTRL_A, {24'h0, a8});
			rc(`TMWC_OFF_CTRL_A, {24'h0, a8 & 8'hF3});
			rc(`TMWC_OFF_CTRL_B, {27'h0, m[3:2], 3'h0});
			if (m < 4'hD || m == 4'hF) begin
				chk(waveConnA, expConn(oa, m, 1'h1));
				chk(waveConnB, expConn(ob, m, 1'h0));
				chk(pinA, (dirA && expConn(oa, m, 1'h1)) ? waveOutA : 1'h1);
			end
		end
		// ---------------------------------------
		// Force strobes in CTC, then in fast PWM
		// ---------------------------------------
		wr(`TMWC_OFF_COUNT, 32'h1234);
		chk(wResp, `TMWC_RESP_OKAY);
		wr(`TMWC_OFF_CTRL_B, 32'h08);
		for (int i = 0; i < 4; i++) begin
			oa = (i == 0) ? `TMWC_OM_CLR : (i == 1) ? `TMWC_OM_SET : `TMWC_OM_TOG;
			wr(`TMWC_OFF_CTRL_A, {24'h0, oa, oa, 4'hC});
			repeat (3) @(posedge sys_clk);
			chk(waveOutA, i % 2);
			chk(waveOutB, i % 2);
		end
		rc(`TMWC_OFF_COUNT, 32'h1234);
		rc(`TMWC_OFF_FLAGS, 32'h0);
		// Strobes set on purpose in a PWM mode
		wr(`TMWC_OFF_CTRL_A, 32'hAD);
		repeat (3) @(posedge sys_clk);
		chk(waveOutA, 32'h1);
		// ---------------------------------------
		// Fixed TOP limits and overflow points
		// ---------------------------------------
		for (int i = 0; i < 6; i++) begin
			m = (i < 3) ? 4'(i + 1) : 4'(i + 2);
			top = (16'h0100 << (i % 3)) - 16'h1;
			wr(`TMWC_OFF_CTRL_A, {24'h0, `TMWC_OM_CLR, 4'h0, m[1:0]});
			wr(`TMWC_OFF_COUNT, 32'h0);
			wr(`TMWC_OFF_FLAGS, 32'hF);
			wr(`TMWC_OFF_CTRL_B, {27'h0, m[3:2], `TMWC_CS_D1});
			repeat (4) begin
				repeat (1 + $urandom % 97) @(posedge sys_clk);
				rd(`TMWC_OFF_COUNT, d, r);
				chk(d <= top, 32'h1);
			end
			repeat (2 * top) @(posedge sys_clk);
			rd(`TMWC_OFF_FLAGS, d, r);
			chk(d[`TMWC_F_OVF], 32'h1);
			wr(`TMWC_OFF_CTRL_B, 32'h0);
			rd(`TMWC_OFF_COUNT, d, r);
			chk(waveOutA, (i < 3) ? 1 : (d == 0));
		end
		// ---------------------------------------
		// External count edges, prescaler, capture
		// ---------------------------------------
		wr(`TMWC_OFF_CTRL_A, 32'h0);
		for (int i = 0; i < 2; i++) begin
			wr(`TMWC_OFF_COUNT, 32'h0);
			wr(`TMWC_OFF_CTRL_B, {29'h0, (i != 0) ? `TMWC_CS_EXTR : `TMWC_CS_EXTF});
			repeat (3) begin
				extLvl <= 1'h1;
				repeat (8) @(posedge sys_clk);
				extLvl <= 1'h0;
				repeat (8) @(posedge sys_clk);
			end
			wr(`TMWC_OFF_CTRL_B, 32'h0);
			rc(`TMWC_OFF_COUNT, 32'h3);
		end
		wr(`TMWC_OFF_COUNT, 32'h0);
		wr(`TMWC_OFF_CTRL_B, {29'h0, `TMWC_CS_D8});
		repeat (160) @(posedge sys_clk);
		wr(`TMWC_OFF_CTRL_B, 32'h0);
		rd(`TMWC_OFF_COUNT, d, r);
		chk(d >= 19 && d <= 22, 32'h1);
		for (int i = 0; i < 2; i++) begin
			wr(`TMWC_OFF_FLAGS, 32'hF);
			wr(`TMWC_OFF_CTRL_B, {24'h0, 1'($urandom), 1'(i == 0), 3'h0, `TMWC_CS_D1});
			capLvl <= 1'(i == 0);
			repeat (20) @(posedge sys_clk);
			rd(`TMWC_OFF_FLAGS, d, r);
			chk(d[`TMWC_F_CAPT], 32'h1);
			rd(`TMWC_OFF_CAPT, d, r);
			chk(d != 32'h0, 32'h1);
		end
		end_sim;
	end
endmodule // tmwc_timer16_tb
